// file: src/tcc_pkg.sv
// Purpose: Shared constants and types for the tool change code transfer block
// Assumes: 32-bit AXI4-Lite register access, 8-bit tool and pocket numbers
// Notes: Tool table entry holds pocket, pocket-valid, special and fixed-pocket bits
package tcc_pkg;

    localparam int TOOL_W = 8;
    localparam int WORD_W = 16;
    localparam int ENTRY_W = 11;
    localparam int DEPTH = 256;
    localparam int ADDR_W = 8;

    // Tool table entry layout
    localparam int E_POCKET_LSB = 0;
    localparam int E_HAS_POCKET = 8;
    localparam int E_SPECIAL = 9;
    localparam int E_FIXED = 10;

    localparam logic [TOOL_W-1:0] POCKET_NONE = 8'hff;
    localparam logic [TOOL_W-1:0] TOOL_CLEAR = 8'h00;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TOOL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_TADDR = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_TDATA = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_SPINDLE = 8'h14;

    // CTRL bits, write one to start
    localparam int CTRL_CALL = 0;
    localparam int CTRL_DEF = 1;

    // STATUS bits
    localparam int ST_BUSY = 0;
    localparam int ST_CALL_STB = 1;
    localparam int ST_DEF_STB = 2;
    localparam int ST_FOLLOWS = 3;
    localparam int ST_SPECIAL = 4;
    localparam int ST_CLS_LSB = 8;
    localparam int ST_ARM = 12;
    localparam int ST_HOME = 13;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CLS_NORMAL,
        CLS_MANUAL,
        CLS_SPECIAL
    } tcc_class_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_LOOK,
        S_PLAN,
        S_XFER,
        S_REL
    } tcc_state_t;

    // Spindle starts empty, treated as a manual tool with number 0
    localparam tcc_class_t OLD_CLS_RST = CLS_MANUAL;
    localparam logic [TOOL_W-1:0] OLD_TOOL_RST = 8'h00;

    function automatic tcc_class_t tcc_classify(input logic [ENTRY_W-1:0] e);
        tcc_class_t c;
        c = CLS_MANUAL;
        if (e[E_SPECIAL]) begin
            c = CLS_SPECIAL;
        end else if (e[E_HAS_POCKET]) begin
            c = CLS_NORMAL;
        end
        return c;
    endfunction

endpackage

// file: src/tcc_tool_mem.sv
// Purpose: Tool table storage, one entry per tool number
// Assumes: One write port from software, one read port for the sequencer
// Notes: Read data is registered, valid one cycle after the address
`timescale 1ns/1ps
module tcc_tool_mem
    import tcc_pkg::*;
(
    input wire logic aclk,
    input wire logic we,
    input wire logic [TOOL_W-1:0] waddr,
    input wire logic [ENTRY_W-1:0] wdata,
    input wire logic [TOOL_W-1:0] raddr,
    output logic [ENTRY_W-1:0] rdata
);

    logic [ENTRY_W-1:0] mem [DEPTH];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        rdata <= mem[raddr];
    end

endmodule

// file: src/tcc_top.sv
// Purpose: Hands pocket and tool numbers to the magazine controller on tool change
// Assumes: Controller answers each strobe with a level feedback, drops it after
// Notes: Registers over AXI4-Lite; tool table held in tcc_tool_mem
// Functional notes
// - Tool is normal, manual or special
// - Normal after normal: one transfer, called tool
// - Flag second transfer with first strobe
// - Second transfer waits for first feedback
// - Tool number 0 means clear spindle
// - Pocket 255 means no magazine pocket
// - Arm order 0: old first, then new
// - Arm order 1: new first, then old
// - After manual: 255/0 first, then new
// - Manual after tool: old/0, then 255/new
// - Manual after manual: one transfer, pocket 255
// - Return home from flag or fixed field
// - Special after special, no return: one sequence
// - Special after normal: arm order only
// - Special tool called indicator, self-managed
// - Preselect uses its own strobe and feedback
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tcc_top
    import tcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [WORD_W-1:0] pocket_word,
    output logic [WORD_W-1:0] tool_word,
    output logic tool_call_strobe,
    output logic tool_preselect_command_strobe,
    output logic second_code_follows,
    output logic special_tool_called,
    input wire logic tool_call_feedback,
    input wire logic tool_preselect_command_feedback,
    input wire logic arm_order_select,
    input wire logic special_return_home
);

    tcc_state_t state_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic aw_full_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_full_r;
    logic wr_go;
    logic busy;
    logic [TOOL_W-1:0] tool_reg_r;
    logic [TOOL_W-1:0] taddr_r;
    logic tbl_we;
    logic call_go;
    logic def_go;
    logic is_def_r;
    logic [TOOL_W-1:0] call_tool_r;
    logic [ENTRY_W-1:0] entry;
    logic arm_r;
    logic home_r;
    tcc_class_t old_cls_r;
    logic [TOOL_W-1:0] old_tool_r;
    logic [TOOL_W-1:0] old_pocket_r;
    logic old_fixed_r;
    tcc_class_t new_cls_r;
    logic [TOOL_W-1:0] new_pocket_r;
    logic new_fixed_r;
    logic pending_r;
    logic [TOOL_W-1:0] sec_pocket_r;
    logic [TOOL_W-1:0] sec_tool_r;
    logic feedback;
    tcc_class_t plan_cls;
    logic [TOOL_W-1:0] plan_pocket;
    logic plan_two;
    logic plan_new_first;
    logic [TOOL_W-1:0] p1_pocket;
    logic [TOOL_W-1:0] p1_tool;
    logic [TOOL_W-1:0] p2_pocket;
    logic [TOOL_W-1:0] p2_tool;

    assign busy = (state_r != S_IDLE);
    assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
    assign tbl_we = wr_go && (awaddr_r == ADDR_TDATA) && !busy;
    assign call_go = wr_go && (awaddr_r == ADDR_CTRL) && wstrb_r[0] && wdata_r[CTRL_CALL]
        && !busy;
    assign def_go = wr_go && (awaddr_r == ADDR_CTRL) && wstrb_r[0] && wdata_r[CTRL_DEF]
        && !busy && !wdata_r[CTRL_CALL];
    assign feedback = is_def_r ? tool_preselect_command_feedback : tool_call_feedback;

    tcc_tool_mem u_mem (
        .aclk(aclk),
        .we(tbl_we),
        .waddr(taddr_r),
        .wdata(wdata_r[ENTRY_W-1:0]),
        .raddr(call_tool_r),
        .rdata(entry)
    );

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_go) begin
                w_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (awaddr_r)
                ADDR_CTRL, ADDR_TOOL, ADDR_TADDR, ADDR_TDATA: s_axi_bresp <= RESP_OKAY;
                ADDR_STATUS, ADDR_SPINDLE: s_axi_bresp <= RESP_OKAY;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software registers; tool number and table locked while busy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tool_reg_r <= '0;
            taddr_r <= '0;
        end else if (wr_go && !busy && wstrb_r[0]) begin
            if (awaddr_r == ADDR_TOOL) begin
                tool_reg_r <= wdata_r[TOOL_W-1:0];
            end
            if (awaddr_r == ADDR_TADDR) begin
                taddr_r <= wdata_r[TOOL_W-1:0];
            end
        end
    end

    // Read channel, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= '0;
                case (s_axi_araddr)
                    ADDR_CTRL: s_axi_rdata <= '0;
                    ADDR_TOOL: s_axi_rdata[TOOL_W-1:0] <= tool_reg_r;
                    ADDR_TADDR: s_axi_rdata[TOOL_W-1:0] <= taddr_r;
                    ADDR_TDATA: s_axi_rdata <= '0;
                    ADDR_STATUS: begin
                        s_axi_rdata[ST_BUSY] <= busy;
                        s_axi_rdata[ST_CALL_STB] <= tool_call_strobe;
                        s_axi_rdata[ST_DEF_STB] <= tool_preselect_command_strobe;
                        s_axi_rdata[ST_FOLLOWS] <= second_code_follows;
                        s_axi_rdata[ST_SPECIAL] <= special_tool_called;
                        s_axi_rdata[ST_CLS_LSB +: 2] <= old_cls_r;
                        s_axi_rdata[ST_ARM] <= arm_order_select;
                        s_axi_rdata[ST_HOME] <= special_return_home;
                    end
                    ADDR_SPINDLE: begin
                        s_axi_rdata[TOOL_W-1:0] <= old_tool_r;
                        s_axi_rdata[2*TOOL_W-1:TOOL_W] <= old_pocket_r;
                    end
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign plan_cls = tcc_classify(entry);
    assign plan_pocket = (plan_cls == CLS_MANUAL) ? POCKET_NONE
        : entry[E_POCKET_LSB +: TOOL_W];

    always_comb begin
        plan_two = 1'b1;
        plan_new_first = 1'b0;
        p1_pocket = (old_cls_r == CLS_MANUAL) ? POCKET_NONE : old_pocket_r;
        p1_tool = TOOL_CLEAR;
        p2_pocket = plan_pocket;
        p2_tool = call_tool_r;
        if (old_cls_r == CLS_NORMAL && plan_cls == CLS_NORMAL) begin
            plan_two = 1'b0;
        end else if (old_cls_r == CLS_MANUAL && plan_cls == CLS_MANUAL) begin
            plan_two = 1'b0;
        end else if (old_cls_r == CLS_SPECIAL && plan_cls == CLS_SPECIAL
                     && !(home_r || old_fixed_r)) begin
            plan_two = 1'b0;
        end else if (old_cls_r == CLS_MANUAL || plan_cls == CLS_MANUAL) begin
            plan_new_first = 1'b0;
        end else begin
            plan_new_first = arm_r;
        end
        // Single transfers carry the called tool
        if (plan_new_first || !plan_two) begin
            p1_pocket = plan_pocket;
            p1_tool = call_tool_r;
            p2_pocket = (old_cls_r == CLS_MANUAL) ? POCKET_NONE : old_pocket_r;
            p2_tool = TOOL_CLEAR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= S_IDLE;
            is_def_r <= 1'b0;
            call_tool_r <= '0;
            arm_r <= 1'b0;
            home_r <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (call_go || def_go) begin
                        state_r <= S_LOOK;
                        is_def_r <= def_go;
                        call_tool_r <= tool_reg_r;
                        arm_r <= arm_order_select;
                        home_r <= special_return_home;
                    end
                end
                S_LOOK: state_r <= S_PLAN;
                S_PLAN: state_r <= S_XFER;
                S_XFER: begin
                    if (feedback) begin
                        state_r <= S_REL;
                    end
                end
                S_REL: begin
                    if (!feedback) begin
                        state_r <= pending_r ? S_XFER : S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Presented words and strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pocket_word <= '0;
            tool_word <= '0;
            tool_call_strobe <= 1'b0;
            tool_preselect_command_strobe <= 1'b0;
            second_code_follows <= 1'b0;
            pending_r <= 1'b0;
            sec_pocket_r <= '0;
            sec_tool_r <= '0;
        end else begin
            case (state_r)
                S_PLAN: begin
                    pocket_word <= {{(WORD_W-TOOL_W){1'b0}}, is_def_r ? plan_pocket : p1_pocket};
                    tool_word <= {{(WORD_W-TOOL_W){1'b0}}, is_def_r ? call_tool_r : p1_tool};
                    tool_preselect_command_strobe <= is_def_r;
                    tool_call_strobe <= !is_def_r;
                    second_code_follows <= !is_def_r && plan_two;
                    pending_r <= !is_def_r && plan_two;
                    sec_pocket_r <= p2_pocket;
                    sec_tool_r <= p2_tool;
                end
                S_XFER: begin
                    if (feedback) begin
                        tool_call_strobe <= 1'b0;
                        tool_preselect_command_strobe <= 1'b0;
                    end
                end
                S_REL: begin
                    if (!feedback && pending_r) begin
                        pocket_word <= {{(WORD_W-TOOL_W){1'b0}}, sec_pocket_r};
                        tool_word <= {{(WORD_W-TOOL_W){1'b0}}, sec_tool_r};
                        tool_call_strobe <= 1'b1;
                        pending_r <= 1'b0;
                    end else if (!feedback) begin
                        second_code_follows <= 1'b0;
                    end
                end
                default: begin
                    tool_call_strobe <= 1'b0;
                    tool_preselect_command_strobe <= 1'b0;
                end
            endcase
        end
    end

    // Spindle contents, updated once a tool change completes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            old_cls_r <= OLD_CLS_RST;
            old_tool_r <= OLD_TOOL_RST;
            old_pocket_r <= POCKET_NONE;
            old_fixed_r <= 1'b0;
            new_cls_r <= OLD_CLS_RST;
            new_pocket_r <= POCKET_NONE;
            new_fixed_r <= 1'b0;
        end else begin
            if (state_r == S_PLAN && !is_def_r) begin
                new_cls_r <= plan_cls;
                new_pocket_r <= plan_pocket;
                new_fixed_r <= entry[E_FIXED];
            end
            if (state_r == S_REL && !feedback && !pending_r && !is_def_r) begin
                old_cls_r <= new_cls_r;
                old_tool_r <= call_tool_r;
                old_pocket_r <= new_pocket_r;
                old_fixed_r <= new_fixed_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            special_tool_called <= 1'b0;
        end else if (state_r == S_PLAN && !is_def_r) begin
            special_tool_called <= (plan_cls == CLS_SPECIAL);
        end
    end

endmodule

// file: bench/tcc_top_properties.sv
// Purpose: Port checks of the tool call and preselect handshakes
// Assumes: One clock, synchronous active-low reset
// Notes: Attached to tcc_top by the bind at the foot
`timescale 1ns/1ps
module tcc_top_properties
    import tcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WORD_W-1:0] pocket_word,
    input wire logic [WORD_W-1:0] tool_word,
    input wire logic tool_call_strobe,
    input wire logic tool_preselect_command_strobe,
    input wire logic second_code_follows,
    input wire logic special_tool_called,
    input wire logic tool_call_feedback,
    input wire logic tool_preselect_command_feedback
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    call_hold_a: assert property (
        tool_call_strobe && !tool_call_feedback |=> tool_call_strobe
        && $stable(pocket_word) && $stable(tool_word))
        else $error("call words or strobe changed before feedback");
    call_drop_a: assert property (
        tool_call_strobe && tool_call_feedback |=> !tool_call_strobe)
        else $error("call strobe kept after feedback");
    def_hold_a: assert property (
        tool_preselect_command_strobe && !tool_preselect_command_feedback |=> tool_preselect_command_strobe
        && $stable(pocket_word) && $stable(tool_word))
        else $error("preselect words or strobe changed before feedback");
    def_drop_a: assert property (
        tool_preselect_command_strobe && tool_preselect_command_feedback |=> !tool_preselect_command_strobe)
        else $error("preselect strobe kept after feedback");
    second_wait_a: assert property (
        $rose(tool_call_strobe) |-> !$past(tool_call_feedback))
        else $error("call strobe raised while feedback still high");
    follow_start_a: assert property (
        $rose(second_code_follows) |-> $rose(tool_call_strobe))
        else $error("follow flag not raised with first strobe");
    follow_keep_a: assert property (
        second_code_follows && tool_call_strobe |=> second_code_follows)
        else $error("follow flag dropped during a transfer");
    follow_end_a: assert property (
        $fell(second_code_follows) |-> !tool_call_strobe && !$past(tool_call_feedback))
        else $error("follow flag dropped before last feedback fell");
    strobe_excl_a: assert property (
        !(tool_call_strobe && tool_preselect_command_strobe))
        else $error("call and preselect strobes both high");
    special_keep_a: assert property (
        tool_call_strobe |=> $stable(special_tool_called))
        else $error("special flag changed during a transfer");
endmodule

bind tcc_top tcc_top_properties tcc_top_properties_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .pocket_word(pocket_word),
    .tool_word(tool_word),
    .tool_call_strobe(tool_call_strobe),
    .tool_preselect_command_strobe(tool_preselect_command_strobe),
    .second_code_follows(second_code_follows),
    .special_tool_called(special_tool_called),
    .tool_call_feedback(tool_call_feedback),
    .tool_preselect_command_feedback(tool_preselect_command_feedback)
);

// file: bench/tcc_plc_model.sv
// Purpose: Magazine controller side of one strobe and feedback handshake
// Assumes: Feedback is a level answered dly+1 cycles after each strobe edge
// Notes: One instance for tool call, one for preselect
`timescale 1ns/1ps
module tcc_plc_model
    import tcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] dly,
    input wire logic strobe,
    input wire logic [WORD_W-1:0] tool_word,
    output logic feedback,
    output logic spindle_empty
);
    logic [3:0] cnt_r;
    logic take;

    assign take = (strobe != feedback) && (cnt_r >= dly);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            feedback <= 1'b0;
        end else if (take) begin
            feedback <= strobe;
        end
    end

    // Slow answers
    always_ff @(posedge aclk) begin
        if (!aresetn || take || strobe == feedback) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spindle_empty <= 1'b1;
        end else if (take && strobe) begin
            spindle_empty <= (tool_word[TOOL_W-1:0] == TOOL_CLEAR);
        end
    end
endmodule

// file: bench/tb.sv
// Purpose: Tool change sequences driven through the register bus
// Assumes: Tool table 1,2 normal, 3,4 manual, 5..7 special (6 fixed pocket)
// Notes: Transfers captured at each rising strobe
`timescale 1ns/1ps
module tb
    import tcc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [WORD_W-1:0] pw, tw;
    logic cs, ds, fol, spc, cfb, dfb, emp, cs_d = 1'b0, ds_d = 1'b0;
    logic arm = 1'b0, home = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [7:0] qp[$], qt[$], dpv, dtv;
    logic qf[$];
    int n_checks = 0, err_total = 0, dn = 0, k;
    logic [31:0] tab [8] = '{32'h0, 32'h105, 32'h107, 32'h0, 32'h0, 32'h309, 32'h70b, 32'h30c};

    tcc_top tcc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pocket_word(pw), .tool_word(tw), .tool_call_strobe(cs),
        .tool_preselect_command_strobe(ds), .second_code_follows(fol), .special_tool_called(spc),
        .tool_call_feedback(cfb), .tool_preselect_command_feedback(dfb), .arm_order_select(arm),
        .special_return_home(home));
    tcc_plc_model plc_call (.aclk(aclk), .aresetn(aresetn), .dly(dly), .strobe(cs),
        .tool_word(tw), .feedback(cfb), .spindle_empty(emp));
    tcc_plc_model plc_def (.aclk(aclk), .aresetn(aresetn), .dly(dly), .strobe(ds),
        .tool_word(tw), .feedback(dfb), .spindle_empty());

    initial begin
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (cs && !cs_d) begin
            qp.push_back(pw[7:0]);
            qt.push_back(tw[7:0]);
            qf.push_back(fol);
        end
        if (ds && !ds_d) begin
            dpv = pw[7:0];
            dtv = tw[7:0];
            dn++;
        end
        cs_d <= cs;
        ds_d <= ds;
    end

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic hang();
        err_total++;
        end_of_test();
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int i;
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 64 && !done; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                chk(bresp, er);
            end
        end
        if (!done) hang();
    endtask

    task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        int i;
        logic done;
        done = 1'b0;
        v = 32'h0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 64 && !done; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                v = rdata;
                chk(rresp, er);
            end
        end
        if (!done) hang();
    endtask

    // Second pair is absent when p2 is zero
    task automatic do_call(input logic [7:0] t, input logic a, input logic h,
        input logic [3:0] w, input logic [7:0] p1, input logic [7:0] t1,
        input logic [7:0] p2, input logic [7:0] t2, input logic sp);
        int i;
        int n;
        logic [31:0] v;
        n = (p2 != 8'h00) ? 2 : 1;
        @(posedge aclk);
        arm <= a;
        home <= h;
        dly <= w;
        qp.delete();
        qt.delete();
        qf.delete();
        axw(ADDR_TOOL, {24'h0, t}, RESP_OKAY);
        axw(ADDR_CTRL, 32'h1, RESP_OKAY);
        for (i = 0; i < 400 && qp.size() < n; i++) @(posedge aclk);
        v = 32'h1;
        for (i = 0; i < 100 && v[ST_BUSY] !== 1'b0; i++) axr(ADDR_STATUS, RESP_OKAY, v);
        if (v[ST_BUSY] !== 1'b0 || qp.size() != n) hang();
        chk(qp[0], p1);
        chk(qt[0], t1);
        chk(qf[0], n == 2);
        if (n == 2) begin
            chk(qp[1], p2);
            chk(qt[1], t2);
            chk(qf[1], 1'b1);
        end
        chk(spc, sp);
        chk(emp, (n == 2) ? (t2 == 8'h00) : (t1 == 8'h00));
        axr(ADDR_SPINDLE, RESP_OKAY, v);
        chk(v, {16'h0, ((t1 == t) ? p1 : p2), t});
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axr(ADDR_STATUS, RESP_OKAY, d);
        chk(d, 32'h100);
        axr(ADDR_SPINDLE, RESP_OKAY, d);
        chk(d, 32'hff00);
        axr(8'h18, RESP_SLVERR, d);
        axw(8'h18, 32'h1, RESP_SLVERR);
        axr(ADDR_TDATA, RESP_OKAY, d);
        chk(d, 32'h0);
        for (k = 1; k < 8; k++) begin
            axw(ADDR_TADDR, k, RESP_OKAY);
            axw(ADDR_TDATA, tab[k], RESP_OKAY);
        end
        axr(ADDR_TADDR, RESP_OKAY, d);
        chk(d, 32'h7);
        do_call(8'h01, 1, 0, 0, 8'hff, 8'h00, 8'h05, 8'h01, 0);
        do_call(8'h02, 0, 1, 2, 8'h07, 8'h02, 8'h00, 8'h00, 0);
        do_call(8'h05, 0, 1, 1, 8'h07, 8'h00, 8'h09, 8'h05, 1);
        do_call(8'h07, 1, 0, 3, 8'h0c, 8'h07, 8'h00, 8'h00, 1);
        do_call(8'h06, 1, 1, 0, 8'h0b, 8'h06, 8'h0c, 8'h00, 1);
        do_call(8'h05, 0, 0, 2, 8'h0b, 8'h00, 8'h09, 8'h05, 1);
        do_call(8'h01, 1, 0, 1, 8'h05, 8'h01, 8'h09, 8'h00, 0);
        do_call(8'h03, 1, 1, 0, 8'h05, 8'h00, 8'hff, 8'h03, 0);
        do_call(8'h04, 0, 0, 2, 8'hff, 8'h04, 8'h00, 8'h00, 0);
        do_call(8'h06, 1, 0, 1, 8'hff, 8'h00, 8'h0b, 8'h06, 1);
        do_call(8'h03, 0, 0, 0, 8'h0b, 8'h00, 8'hff, 8'h03, 0);
        axw(ADDR_TOOL, 32'h2, RESP_OKAY);
        axw(ADDR_CTRL, 32'h2, RESP_OKAY);
        for (k = 0; k < 400 && dn == 0; k++) @(posedge aclk);
        if (dn == 0) hang();
        chk(dpv, 8'h07);
        chk(dtv, 8'h02);
        repeat (20) @(posedge aclk);
        axr(ADDR_SPINDLE, RESP_OKAY, d);
        chk(d, 32'hff03);
        end_of_test();
    end
endmodule
